// ---- inc/ccs_pkg.sv ----
// constants and types shared by the cpu clock switch sequencer
package ccs_pkg;
    // ======================================================
    // register layout and reset values
    localparam logic [7:0] PCC_RST = 8'h02;
    localparam logic [7:0] CSS_RST = 8'h00;
    localparam logic [7:0] PCC_WR_MASK = 8'h82;
    localparam int PCC_MCC_BIT = 7;
    localparam int PCC_SPD_BIT = 1;
    localparam int CSS_SRC_BIT = 4;
    localparam int CSS_STAT_BIT = 5;
    // ======================================================
    // switch latencies in cycles of the old cpu clock
    localparam int LAT_W = 10;
    localparam logic [LAT_W-1:0] LAT_TO_SLOW = 10'h004;
    localparam logic [LAT_W-1:0] LAT_SHORT = 10'h002;
    // ======================================================
    // reset sequencing counts
    localparam logic [2:0] STRAP_WAIT = 3'h5;
    localparam int STAB_W = 17;
    // ======================================================
    // types
    typedef enum logic [1:0] {SRC_FAST, SRC_SLOW, SRC_SUB} ccs_src_e;
    typedef enum logic [1:0] {ST_STRAP, ST_STAB, ST_RUN, ST_SWITCH} ccs_state_e;
endpackage

// ---- core/ccs_pin_sync.sv ----
// three-stage pin synchroniser with agreement filter
`timescale 1ns/1ns
module ccs_pin_sync (
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic pin,
    output logic level_q
);
    logic s1_q;
    logic s2_q;
    logic s3_q;

    // ======================================================
    // chain; first stage feeds only the second
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            s1_q <= 1'b0;
            s2_q <= 1'b0;
            s3_q <= 1'b0;
            level_q <= 1'b0;
        end else begin
            s1_q <= pin;
            s2_q <= s1_q;
            s3_q <= s2_q;
            if (s2_q == s3_q) begin
                level_q <= s3_q; // change counts once stages two and three agree
            end
        end
    end
endmodule

// ---- core/ccs_clock_switch.sv ----
// cpu clock source selector with glitch-free switch sequencing
`timescale 1ns/1ns
// Summary of operation
// - cpu clock from speed bit and source bit
// - old clock runs on after a write
// - crystal: 4, 2fx/fxT, 2 clock latencies
// - rc: fast-to-sub takes 2fcc/fxT clocks
// - latency counted in old cpu clocks
// - reset pin holds cpu, release starts oscillator
// - crystal: wait 2^15 main periods after reset
// - rc: wait 2^7 main periods after reset
// - execution starts on slow main clock
// - clearing stop bit restarts main oscillator
// - source bit: 0 main, 1 subsystem
// - status bit 5 shows actual source
// - reset loads processor clock control 02h
// - stop bit stops main only on subclock
module ccs_clock_switch import ccs_pkg::*; #(
    parameter int XTAL_SUB_LAT = 306,
    parameter int RC_SUB_LAT = 122,
    parameter int SLOW_SUB_LAT = 153,
    parameter int STAB_XTAL = 32768,
    parameter int STAB_RC = 128
) (
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic main_osc_in,
    input wire logic sub_osc_in,
    input wire logic osc_sel_rc,
    input wire logic pcc_wr,
    input wire logic [7:0] pcc_wdata,
    input wire logic css_wr,
    input wire logic [7:0] css_wdata,
    output logic [7:0] processor_clock_ctrl_q,
    output logic [7:0] subclock_ctrl_q,
    output logic cpu_clk_q,
    output logic cpu_rst_n_q,
    output logic main_osc_en_q
);
    // ======================================================
    // parameter checks
    if (XTAL_SUB_LAT < 2 || XTAL_SUB_LAT >= 1024 || RC_SUB_LAT < 2 || RC_SUB_LAT >= 1024 ||
        SLOW_SUB_LAT < 2 || SLOW_SUB_LAT >= 1024) begin : g_bad_lat
        $error("switch latency out of range");
    end
    if (STAB_XTAL < 2 || STAB_XTAL >= 65536 || STAB_RC < 2 || STAB_RC >= 65536) begin : g_bad_stab
        $error("stabilisation count out of range");
    end

    logic main_lvl;
    logic sub_lvl;
    logic sel_lvl;
    logic main_lvl_q;
    logic [1:0] div_q;
    logic [2:0] strap_q;
    logic rc_mode_q;
    logic [STAB_W-1:0] stab_q;
    logic [LAT_W-1:0] lat_q;
    logic [LAT_W-1:0] lat_d;
    logic [LAT_W-1:0] lat_for;
    logic cpu_source_select_q;
    logic cpu_source_select_d;
    logic [7:0] pcc_d;
    ccs_state_e st_q;
    ccs_state_e st_d;
    ccs_src_e src_q;
    ccs_src_e src_d;
    ccs_src_e pend_q;
    ccs_src_e pend_d;
    ccs_src_e tgt;
    logic main_rise;
    logic fast_clk;
    logic slow_clk;
    logic cur_clk;
    logic new_clk;
    logic next_clk;
    logic cpu_rise;
    logic stab_end;
    logic [STAB_W-1:0] stab_last;

    // ======================================================
    // pin synchronisers
    ccs_pin_sync u_main (.core_clk(core_clk), .rstn(rstn), .pin(main_osc_in), .level_q(main_lvl));
    ccs_pin_sync u_sub (.core_clk(core_clk), .rstn(rstn), .pin(sub_osc_in), .level_q(sub_lvl));
    ccs_pin_sync u_sel (.core_clk(core_clk), .rstn(rstn), .pin(osc_sel_rc), .level_q(sel_lvl));

    // ======================================================
    // clock candidates and selection
    assign main_rise = main_lvl & ~main_lvl_q & main_osc_en_q;
    assign fast_clk = div_q[0];
    assign slow_clk = div_q[1];
    assign tgt = cpu_source_select_q ? SRC_SUB :
        (processor_clock_ctrl_q[PCC_SPD_BIT] ? SRC_SLOW : SRC_FAST);
    assign cur_clk = (src_q == SRC_SUB) ? sub_lvl : ((src_q == SRC_SLOW) ? slow_clk : fast_clk);
    assign new_clk = (pend_q == SRC_SUB) ? sub_lvl : ((pend_q == SRC_SLOW) ? slow_clk : fast_clk);
    assign next_clk = (src_d == SRC_SUB) ? sub_lvl : ((src_d == SRC_SLOW) ? slow_clk : fast_clk);
    assign cpu_rise = cur_clk & ~cpu_clk_q; // edge of the old clock
    assign stab_last = rc_mode_q ? STAB_W'(STAB_RC - 1) : STAB_W'(STAB_XTAL - 1);
    assign stab_end = main_rise && (stab_q == stab_last);

    // latency lookup; fast clock counts twice the edges of slow for the same time
    assign lat_for = (tgt == SRC_FAST || src_q == SRC_SUB) ? LAT_SHORT :
        (tgt == SRC_SLOW) ? LAT_TO_SLOW :
        (src_q == SRC_SLOW) ? LAT_W'(SLOW_SUB_LAT) :
        (rc_mode_q ? LAT_W'(RC_SUB_LAT) : LAT_W'(XTAL_SUB_LAT));

    // software writes; only defined bits are kept
    assign pcc_d = pcc_wr ? (pcc_wdata & PCC_WR_MASK) : processor_clock_ctrl_q;
    assign cpu_source_select_d = css_wr ? css_wdata[CSS_SRC_BIT] : cpu_source_select_q;

    // ======================================================
    // sequencer next state
    always_comb begin
        st_d = st_q;
        lat_d = lat_q;
        pend_d = pend_q;
        src_d = src_q;
        case (st_q)
            ST_STRAP: begin
                if (strap_q == STRAP_WAIT) begin
                    st_d = ST_STAB;
                end
            end
            ST_STAB: begin
                if (stab_end) begin
                    st_d = ST_RUN; // start on slow main clock
                end
            end
            ST_RUN: begin
                if (tgt != src_q) begin
                    st_d = ST_SWITCH; // old source kept meanwhile
                    pend_d = tgt;
                    lat_d = lat_for;
                end
            end
            ST_SWITCH: begin
                if (lat_q != '0) begin
                    if (cpu_rise) begin
                        lat_d = lat_q - 1'b1;
                    end
                end else if (!cur_clk && !new_clk && !cpu_clk_q) begin
                    src_d = pend_q; // both low, no runt
                    st_d = ST_RUN;
                end
            end
            default: st_d = ST_STRAP;
        endcase
    end

    // ======================================================
    // sequencer state
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            st_q <= ST_STRAP;
            src_q <= SRC_SLOW;
            pend_q <= SRC_SLOW;
            lat_q <= '0;
        end else begin
            st_q <= st_d;
            src_q <= src_d;
            pend_q <= pend_d;
            lat_q <= lat_d;
        end
    end

    // strap capture after release and stabilisation count
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            strap_q <= '0;
            rc_mode_q <= 1'b0;
            stab_q <= '0;
        end else begin
            if (st_q == ST_STRAP) begin
                strap_q <= strap_q + 1'b1;
                rc_mode_q <= sel_lvl;
            end
            if (st_q == ST_STAB && main_rise) begin
                stab_q <= stab_q + 1'b1;
            end
        end
    end

    // main clock divider
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            main_lvl_q <= 1'b0;
            div_q <= '0;
        end else begin
            main_lvl_q <= main_lvl;
            div_q <= main_rise ? div_q + 1'b1 : div_q;
        end
    end

    // ======================================================
    // registers and outputs
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            processor_clock_ctrl_q <= PCC_RST;
            cpu_source_select_q <= CSS_RST[CSS_SRC_BIT];
            subclock_ctrl_q <= CSS_RST;
            cpu_clk_q <= 1'b0;
            cpu_rst_n_q <= 1'b0; // cpu held while pin low
            main_osc_en_q <= 1'b0;
        end else begin
            processor_clock_ctrl_q <= pcc_d;
            cpu_source_select_q <= cpu_source_select_d;
            subclock_ctrl_q <= {2'h0, (src_d == SRC_SUB), cpu_source_select_d, 4'h0};
            cpu_clk_q <= next_clk;
            cpu_rst_n_q <= (st_d == ST_RUN) || (st_d == ST_SWITCH);
            main_osc_en_q <= !(pcc_d[PCC_MCC_BIT] && src_d == SRC_SUB);
        end
    end

    // ======================================================
    // assertions
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rstn);

    property p_no_same_cycle;
        (st_q == ST_RUN && tgt != src_q) |=> (src_q == $past(src_q)) [*2];
    endproperty
    a_no_same_cycle: assert property (p_no_same_cycle) else $error("source switched too early");

    property p_fast_lat;
        (st_q == ST_RUN && src_q == SRC_FAST && tgt == SRC_SLOW) |=> lat_q == 10'h004;
    endproperty
    a_fast_lat: assert property (p_fast_lat) else $error("fast to slow latency wrong");

    property p_rc_sub_lat;
        (st_q == ST_RUN && rc_mode_q && src_q == SRC_FAST && tgt == SRC_SUB)
            |=> lat_q == LAT_W'(RC_SUB_LAT);
    endproperty
    a_rc_sub_lat: assert property (p_rc_sub_lat) else $error("rc sub latency wrong");

    property p_count_on_edge;
        (st_q == ST_SWITCH && !cpu_rise) |=> $stable(lat_q);
    endproperty
    a_count_on_edge: assert property (p_count_on_edge) else $error("count without old edge");

    property p_no_runt;
        (src_q != $past(src_q)) |-> !$past(cpu_clk_q) && !cpu_clk_q;
    endproperty
    a_no_runt: assert property (p_no_runt) else $error("handover with clock high");

    property p_status_at_handover;
        $changed(subclock_ctrl_q[CSS_STAT_BIT]) |-> $past(st_q) == ST_SWITCH;
    endproperty
    a_status_at_handover: assert property (p_status_at_handover) else $error("status moved early");

    property p_start_slow;
        $rose(cpu_rst_n_q) |-> src_q == SRC_SLOW && $past(stab_q) == stab_last;
    endproperty
    a_start_slow: assert property (p_start_slow) else $error("bad start after wait");

    property p_osc_restart;
        !processor_clock_ctrl_q[PCC_MCC_BIT] && !pcc_wr |=> main_osc_en_q;
    endproperty
    a_osc_restart: assert property (p_osc_restart) else $error("oscillator not running");

    property p_stop_on_sub;
        $fell(main_osc_en_q) |-> src_q == SRC_SUB && processor_clock_ctrl_q[PCC_MCC_BIT];
    endproperty
    a_stop_on_sub: assert property (p_stop_on_sub) else $error("main stopped off subclock");

    property p_status_source;
        subclock_ctrl_q[CSS_STAT_BIT] == (src_q == SRC_SUB);
    endproperty
    a_status_source: assert property (p_status_source) else $error("status mismatch");

    c_to_fast: cover property (st_q == ST_SWITCH && pend_q == SRC_FAST ##1 src_q == SRC_FAST);
    c_to_sub: cover property (st_q == ST_SWITCH && pend_q == SRC_SUB ##1 src_q == SRC_SUB);
    c_run: cover property ($rose(cpu_rst_n_q));
    c_osc_stop: cover property ($fell(main_osc_en_q));
endmodule

// ---- verification/ccs_osc_model.sv ----
// oscillator sources that feed the cpu clock switch sequencer
`timescale 1ns/1ns
module ccs_osc_model #(
    parameter int MAIN_HALF = 12,
    parameter int SUB_HALF = 64
) (
    input wire logic main_en,
    output logic main_osc,
    output logic sub_osc
);
    // ======================================================
    // main oscillator toggles only while enabled and rests low when stopped
    initial begin
        main_osc = 1'b0;
        #1;
        forever begin
            #(MAIN_HALF);
            main_osc = main_en ? ~main_osc : 1'b0;
        end
    end
    // subsystem oscillator is already stable before software selects it
    initial begin
        sub_osc = 1'b0;
        #1;
        forever #(SUB_HALF) sub_osc = ~sub_osc;
    end
endmodule

// ---- verification/test_ccs_clock_switch.sv ----
// self-checking bench for the cpu clock switch sequencer
`timescale 1ns/1ns
module test_ccs_clock_switch;
    logic core_clk = 1'b0;
    logic rstn = 1'b0;
    logic osc_sel_rc = 1'b0;
    logic pcc_wr = 1'b0;
    logic [7:0] pcc_wdata = 8'h00;
    logic css_wr = 1'b0;
    logic [7:0] css_wdata = 8'h00;
    logic main_osc_in, sub_osc_in, cpu_clk_q, cpu_rst_n_q, main_osc_en_q;
    logic [7:0] processor_clock_ctrl_q, subclock_ctrl_q;
    int bad_count = 0;
    int n_checks = 0;
    int t;
    // ======================================================
    // clock, design and oscillator sources
    always #2 core_clk = ~core_clk;
    ccs_clock_switch #(.XTAL_SUB_LAT(4), .RC_SUB_LAT(3), .SLOW_SUB_LAT(3),
        .STAB_XTAL(16), .STAB_RC(8)) dut (.core_clk(core_clk), .rstn(rstn),
        .main_osc_in(main_osc_in), .sub_osc_in(sub_osc_in), .osc_sel_rc(osc_sel_rc),
        .pcc_wr(pcc_wr), .pcc_wdata(pcc_wdata), .css_wr(css_wr), .css_wdata(css_wdata),
        .processor_clock_ctrl_q(processor_clock_ctrl_q), .subclock_ctrl_q(subclock_ctrl_q),
        .cpu_clk_q(cpu_clk_q), .cpu_rst_n_q(cpu_rst_n_q), .main_osc_en_q(main_osc_en_q));
    ccs_osc_model osc (.main_en(main_osc_en_q), .main_osc(main_osc_in),
        .sub_osc(sub_osc_in));
    // ======================================================
    // shared tasks
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("wrong value %s expected %0h seen %0h", name, exp, seen);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge core_clk);
    endtask
    task automatic wr_pcc(input logic [7:0] d);
        pcc_wr = 1'b1;
        pcc_wdata = d;
        cyc(1);
        pcc_wr = 1'b0;
        cyc(1);
    endtask
    task automatic wr_css(input logic [7:0] d);
        css_wr = 1'b1;
        css_wdata = d;
        cyc(1);
        css_wr = 1'b0;
        cyc(1);
    endtask
    task automatic in_range(input string name, input int v, input int lo, input int hi);
        check(name, 32'(v >= lo && v <= hi), 32'h1);
    endtask
    // reset with strap, then count cycles until the cpu leaves reset
    task automatic rst_seq(input logic rc, output int n);
        rstn = 1'b0;
        osc_sel_rc = rc;
        cyc(16);
        check("pcc reset", 32'(processor_clock_ctrl_q), 32'h02);
        check("css reset", 32'(subclock_ctrl_q), 32'h00);
        check("cpu reset held", 32'(cpu_rst_n_q), 32'h0);
        check("osc held", 32'(main_osc_en_q), 32'h0);
        rstn = 1'b1;
        cyc(1);
        check("osc started", 32'(main_osc_en_q), 32'h1);
        n = 1;
        while (cpu_rst_n_q !== 1'b1 && n < 500) begin
            cyc(1);
            n++;
        end
    endtask
    // cycles between two rising edges of the cpu clock
    task automatic period(input string name, input int exp);
        int n;
        n = 0;
        while (cpu_clk_q !== 1'b0 && n < 300) begin cyc(1); n++; end
        while (cpu_clk_q !== 1'b1 && n < 300) begin cyc(1); n++; end
        n = 0;
        do begin cyc(1); n++; end while (cpu_clk_q !== 1'b0 && n < 300);
        while (cpu_clk_q !== 1'b1 && n < 300) begin cyc(1); n++; end
        check(name, 32'(n), 32'(exp));
    endtask
    task automatic wait_stat(input logic v, output int n);
        n = 0;
        while (subclock_ctrl_q[5] !== v && n < 2000) begin cyc(1); n++; end
    endtask
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    // ======================================================
    // watchdog against a hung handover
    initial begin
        repeat (20000) @(posedge core_clk);
        bad_count++;
        end_of_test;
    end
    // ======================================================
    // main sequence
    initial begin
        rst_seq(1'b0, t);
        in_range("crystal stab wait", t, 90, 120);
        period("slow period", 24);
        wr_pcc(8'hff);
        check("pcc mask", 32'(processor_clock_ctrl_q), 32'h82);
        cyc(30);
        check("stop ignored on main", 32'(main_osc_en_q), 32'h1);
        wr_pcc(8'h00);
        cyc(200);
        period("fast period", 12);
        wr_pcc(8'h02);
        cyc(100);
        period("fast to slow", 24);
        wr_pcc(8'h00);
        cyc(100);
        wr_css(8'h10);
        check("css status held", 32'(subclock_ctrl_q), 32'h10);
        wait_stat(1'b1, t);
        in_range("fast to sub", t, 24, 90);
        check("css on sub", 32'(subclock_ctrl_q), 32'h30);
        period("sub period", 32);
        wr_pcc(8'h82);
        cyc(4);
        check("main stopped", 32'(main_osc_en_q), 32'h0);
        wr_pcc(8'h02);
        cyc(2);
        check("main restarted", 32'(main_osc_en_q), 32'h1);
        cyc(200);
        wr_css(8'h00);
        wait_stat(1'b0, t);
        in_range("sub to main", t, 32, 130);
        period("back to slow", 24);
        rst_seq(1'b1, t);
        in_range("rc stab wait", t, 42, 75);
        wr_pcc(8'h00);
        cyc(100);
        wr_css(8'h10);
        wait_stat(1'b1, t);
        in_range("rc fast to sub", t, 24, 90);
        end_of_test;
    end
endmodule
